// *** rtl/drsas_pkg.sv ***
// constants for the read-side active state block
// assumes a 32-bit APB with byte addresses in paddr[7:0]
package drsas_pkg;
	localparam int unsigned PADDR_W = 8;
	localparam logic [7:0] OFF_SRC = 8'h00;
	localparam logic [7:0] OFF_CNT = 8'h04;
	localparam logic [7:0] OFF_DST = 8'h08;
	localparam logic [7:0] OFF_IDX = 8'h0C;
	localparam logic [7:0] OFF_PRXY = 8'h10;
	localparam logic [7:0] OFF_RLD = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [7:0] OFF_CTRL = 8'h1C;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam int unsigned CNT_HI_LSB = 16;
	localparam int unsigned HOST_PRIVILEGE_LEVEL_LVL_BIT = 8;
	localparam int unsigned HOST_ID_LSB = 0;
	localparam logic [2:0] WRAP_SEL_MAX = 3'h5;
	localparam logic MODE_STEP = 1'b0;
	localparam logic MODE_WRAP = 1'b1;
	localparam logic [15:0] CMD_MAX_BYTES = 16'h0040;
	localparam int unsigned CMD_ADDR_LSB = 0;
	localparam int unsigned CMD_BYTES_LSB = 32;
	localparam int unsigned CMD_HOSTID_LSB = 48;
	localparam int unsigned CMD_HOST_PRIVILEGE_LEVEL_BIT = 52;
	localparam int unsigned CMD_W = 53;
	typedef enum logic {ST_IDLE, ST_RUN} drsas_state_t;
endpackage

// *** rtl/drsas_cmd_if.sv ***
// read command stream between issue logic and output buffer
// assumes both ends on the same clock
`timescale 1ns/1ps
interface drsas_cmd_if;
	logic valid;
	logic ready;
	logic [drsas_pkg::CMD_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// *** rtl/drsas_cmd_buf.sv ***
// two-entry skid buffer for read commands
// assumes a synchronous valid/ready sink downstream
`timescale 1ns/1ps
module drsas_cmd_buf (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// stream in and out
	drsas_cmd_if.snk up,
	drsas_cmd_if.src dn
);
	logic out_valid_ff;
	logic skid_valid_ff;
	logic [drsas_pkg::CMD_W-1:0] out_data_ff;
	logic [drsas_pkg::CMD_W-1:0] skid_data_ff;
	wire in_fire = up.valid & ~skid_valid_ff;
	wire out_free = dn.ready | ~out_valid_ff;
	// skid catches a word when the sink stalls, so nothing is lost
	wire nxt_skid_valid = out_free ? 1'b0 : (skid_valid_ff | in_fire);
	wire nxt_out_valid = out_free ? (skid_valid_ff | in_fire) : 1'b1;
	wire load_out = out_free & (skid_valid_ff | in_fire);
	wire load_skid = ~out_free & in_fire;
	wire [drsas_pkg::CMD_W-1:0] out_src = skid_valid_ff ? skid_data_ff : up.data;
	assign up.ready = ~skid_valid_ff;
	assign dn.valid = out_valid_ff;
	assign dn.data = out_data_ff;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_valid_ff <= 1'b0;
			skid_valid_ff <= 1'b0;
			out_data_ff <= '0;
			skid_data_ff <= '0;
		end
		else
		begin
			out_valid_ff <= nxt_out_valid;
			skid_valid_ff <= nxt_skid_valid;
			if (load_out)
				out_data_ff <= out_src;
			if (load_skid)
				skid_data_ff <= up.data;
		end
	end
endmodule // drsas_cmd_buf

// *** rtl/drsas_addr_step.sv ***
// size of the next read and the address after it
// assumes wrap select codes above the 256-bit code act as 256-bit
`timescale 1ns/1ps
module drsas_addr_step (
	// current position
	input wire logic [31:0] addr,
	input wire logic [31:0] bref,
	input wire logic [15:0] rem_bytes,
	// addressing mode
	input wire logic wrap_mode,
	input wire logic [2:0] wrap_sel,
	// results
	output logic [15:0] chunk,
	output logic [31:0] nxt_addr
);
	wire [2:0] fw_eff = (wrap_sel > drsas_pkg::WRAP_SEL_MAX) ? drsas_pkg::WRAP_SEL_MAX : wrap_sel;
	wire [15:0] wrap_bytes = 16'h0001 << fw_eff;
	wire [15:0] limit = (wrap_mode == drsas_pkg::MODE_WRAP) ? wrap_bytes : drsas_pkg::CMD_MAX_BYTES;
	wire [31:0] incrementing_addressing = addr + {16'h0000, chunk};
	wire [31:0] mask = {16'h0000, wrap_bytes - 16'h0001};
	wire [31:0] wrapped = bref + ((incrementing_addressing - bref) & mask);
	assign chunk = (rem_bytes < limit) ? rem_bytes : limit;
	assign nxt_addr = (wrap_mode == drsas_pkg::MODE_WRAP) ? wrapped : incrementing_addressing;
endmodule // drsas_addr_step

// *** rtl/drsas_top.sv ***
// read-side active state of a DMA transfer controller
// assumes the channel controller holds sub_* stable while sub_valid is high
// Function
// - keep 32-bit current source address, advanced per read by mode
// - 16-bit array count remaining, decremented when an array completes
// - 16-bit byte count left in array, reduced by each read size
// - both counts are zero once the request's reads finish
// - destination address always reads zero; destination index reads the source array stride
// - 16-bit source array stride locates each new source array
// - capture one-bit host privilege at submit, 1 means supervisor
// - capture 4-bit host identifier at submit
// - every issued command carries privilege and identifier for endpoint checks
// - keep programmed byte count as reload, zero for an empty request; restore it after each array
// - active state read-only to software, zero after reset
// - mode 0 increments address, mode 1 wraps at configured width
// - 3-bit wrap width code, 8 to 256 bits, 6 and 7 reserved
`timescale 1ns/1ps
module drsas_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// request submit from channel controller
	input wire logic sub_valid,
	output logic sub_ready,
	input wire logic [31:0] sub_src_addr,
	input wire logic [15:0] sub_byte_count,
	input wire logic [15:0] sub_array_count,
	input wire logic [15:0] sub_src_stride,
	input wire logic sub_host_privilege_level,
	input wire logic [3:0] sub_hostid,
	input wire logic sub_addr_mode,
	input wire logic [2:0] sub_wrap_sel,
	// read commands to target endpoints
	output logic cmd_valid,
	input wire logic cmd_ready,
	output logic [31:0] cmd_addr,
	output logic [15:0] cmd_bytes,
	output logic cmd_host_privilege_level,
	output logic [3:0] cmd_hostid,
	// request finished
	output logic done
);
	drsas_pkg::drsas_state_t state_ff;
	drsas_pkg::drsas_state_t nxt_state;
	logic [31:0] src_addr_ff;
	logic [31:0] bref_ff;
	logic [15:0] bytes_left_ff;
	logic [15:0] arrays_left_ff;
	logic [15:0] reload_ff;
	logic [15:0] stride_ff;
	logic host_privilege_level_ff;
	logic [3:0] hostid_ff;
	logic mode_ff;
	logic [2:0] wrap_sel_ff;
	logic done_ff;
	logic sub_ready_ff;
	logic pause_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [15:0] chunk;
	logic [31:0] step_addr;

	drsas_cmd_if issue ();
	drsas_cmd_if outq ();

	drsas_addr_step u_step (
		.addr(src_addr_ff),
		.bref(bref_ff),
		.rem_bytes(bytes_left_ff),
		.wrap_mode(mode_ff),
		.wrap_sel(wrap_sel_ff),
		.chunk(chunk),
		.nxt_addr(step_addr)
	);

	drsas_cmd_buf u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.up(issue.snk),
		.dn(outq.src)
	);

	// submit and issue handshakes
	wire run = (state_ff == drsas_pkg::ST_RUN);
	wire accept = sub_valid & sub_ready_ff;
	wire sub_empty = (sub_byte_count == 16'h0000) | (sub_array_count == 16'h0000);
	// pause only holds back new commands; what is buffered still drains
	wire fire = run & ~pause_ff & issue.ready;
	wire last_arr = (chunk == bytes_left_ff);
	wire last_all = last_arr & (arrays_left_ff == 16'h0001);
	wire next_arr = fire & last_arr & ~last_all;
	wire [31:0] arr_start = bref_ff + {16'h0000, stride_ff};

	assign issue.valid = run & ~pause_ff;
	assign issue.data = {host_privilege_level_ff, hostid_ff, chunk, src_addr_ff};
	assign outq.ready = cmd_ready;

	wire [31:0] nxt_src_addr = accept ? sub_src_addr :
		next_arr ? arr_start :
		fire ? step_addr : src_addr_ff;
	wire [31:0] nxt_bref = accept ? sub_src_addr : next_arr ? arr_start : bref_ff;
	wire [15:0] nxt_bytes_left = accept ? (sub_empty ? 16'h0000 : sub_byte_count) :
		next_arr ? reload_ff :
		fire ? (bytes_left_ff - chunk) : bytes_left_ff;
	wire [15:0] nxt_arrays_left = accept ? (sub_empty ? 16'h0000 : sub_array_count) :
		(fire & last_arr) ? (arrays_left_ff - 16'h0001) : arrays_left_ff;
	wire nxt_done = (accept & sub_empty) | (fire & last_all);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			drsas_pkg::ST_IDLE:
				if (accept & ~sub_empty)
					nxt_state = drsas_pkg::ST_RUN;
			drsas_pkg::ST_RUN:
				if (fire & last_all)
					nxt_state = drsas_pkg::ST_IDLE;
			default:
				nxt_state = drsas_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= drsas_pkg::ST_IDLE;
			src_addr_ff <= drsas_pkg::RST_WORD;
			bref_ff <= drsas_pkg::RST_WORD;
			bytes_left_ff <= drsas_pkg::RST_HALF;
			arrays_left_ff <= drsas_pkg::RST_HALF;
			done_ff <= 1'b0;
			sub_ready_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			src_addr_ff <= nxt_src_addr;
			bref_ff <= nxt_bref;
			bytes_left_ff <= nxt_bytes_left;
			arrays_left_ff <= nxt_arrays_left;
			done_ff <= nxt_done;
			// ready drops the cycle after a take, so one request per take
			sub_ready_ff <= (nxt_state == drsas_pkg::ST_IDLE) & ~accept;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reload_ff <= drsas_pkg::RST_HALF;
			stride_ff <= drsas_pkg::RST_HALF;
			host_privilege_level_ff <= 1'b0;
			hostid_ff <= 4'h0;
			mode_ff <= drsas_pkg::MODE_STEP;
			wrap_sel_ff <= 3'h0;
		end
		else if (accept)
		begin
			reload_ff <= sub_empty ? drsas_pkg::RST_HALF : sub_byte_count;
			stride_ff <= sub_src_stride;
			host_privilege_level_ff <= sub_host_privilege_level;
			hostid_ff <= sub_hostid;
			mode_ff <= sub_addr_mode;
			wrap_sel_ff <= sub_wrap_sel;
		end
	end

	// apb decode
	wire apb_acc = psel & penable & ~pready_ff;
	wire aligned = (paddr[1:0] == 2'b00);
	wire hit_src = aligned & (paddr == drsas_pkg::OFF_SRC);
	wire hit_cnt = aligned & (paddr == drsas_pkg::OFF_CNT);
	wire hit_dst = aligned & (paddr == drsas_pkg::OFF_DST);
	wire hit_idx = aligned & (paddr == drsas_pkg::OFF_IDX);
	wire hit_prxy = aligned & (paddr == drsas_pkg::OFF_PRXY);
	wire hit_rld = aligned & (paddr == drsas_pkg::OFF_RLD);
	wire hit_stat = aligned & (paddr == drsas_pkg::OFF_STAT);
	wire hit_ctrl = aligned & (paddr == drsas_pkg::OFF_CTRL);
	wire hit_any = hit_src | hit_cnt | hit_dst | hit_idx | hit_prxy | hit_rld | hit_stat | hit_ctrl;
	wire ctrl_wr = apb_acc & pwrite & hit_ctrl;

	wire [31:0] rd_cnt = {arrays_left_ff, bytes_left_ff};
	wire [31:0] rd_dst = drsas_pkg::RST_WORD;
	wire [31:0] rd_idx = {16'h0000, stride_ff};
	wire [31:0] rd_prxy = {23'h000000, host_privilege_level_ff, 4'h0, hostid_ff};
	wire [31:0] rd_rld = {16'h0000, reload_ff};
	wire [31:0] rd_stat = {30'h00000000, outq.valid, run};
	wire [31:0] rd_ctrl = {31'h00000000, pause_ff};
	wire [31:0] rd_mux = hit_src ? src_addr_ff :
		hit_cnt ? rd_cnt :
		hit_dst ? rd_dst :
		hit_idx ? rd_idx :
		hit_prxy ? rd_prxy :
		hit_rld ? rd_rld :
		hit_stat ? rd_stat :
		hit_ctrl ? rd_ctrl : drsas_pkg::RST_WORD;
	wire [31:0] nxt_prdata = (apb_acc & ~pwrite) ? rd_mux : prdata_ff;

	// one wait state keeps pready and prdata registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= drsas_pkg::RST_WORD;
			pause_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= apb_acc;
			pslverr_ff <= apb_acc & ~hit_any;
			prdata_ff <= nxt_prdata;
			if (ctrl_wr)
				pause_ff <= pwdata[0];
		end
	end

	// outputs; buffer outputs are its own flops
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign sub_ready = sub_ready_ff;
	assign done = done_ff;
	assign cmd_valid = outq.valid;
	assign cmd_addr = outq.data[drsas_pkg::CMD_ADDR_LSB +: 32];
	assign cmd_bytes = outq.data[drsas_pkg::CMD_BYTES_LSB +: 16];
	assign cmd_hostid = outq.data[drsas_pkg::CMD_HOSTID_LSB +: 4];
	assign cmd_host_privilege_level = outq.data[drsas_pkg::CMD_HOST_PRIVILEGE_LEVEL_BIT];
endmodule // drsas_top

// *** test/drsas_ep.sv ***
// endpoint model that accepts read commands, promptly or with stalls
// assumes the bench watches the command handshake itself
`timescale 1ns/1ps
module drsas_ep (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// stall control and handshake
	input wire logic slow,
	output logic cmd_ready
);
	logic [1:0] cnt_ff;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_ff <= 2'h0;
		else
			cnt_ff <= cnt_ff + 2'h1;
	end
	// takes tagged commands
	// slow mode accepts one cycle in four, enough to fill the buffer
	assign cmd_ready = !slow || (cnt_ff == 2'h3);
endmodule // drsas_ep

// *** test/drsas_props.sv ***
// port assertions for the read-side active state block
// assumes a bind into drsas_top, one clock domain
`timescale 1ns/1ps
module drsas_props (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// submit, commands, finish
	input wire logic sub_valid,
	input wire logic sub_ready,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [31:0] cmd_addr,
	input wire logic [15:0] cmd_bytes,
	input wire logic cmd_host_privilege_level,
	input wire logic [3:0] cmd_hostid,
	input wire logic done
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("apb wait wrong");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	chk_rdata_hold: assert property (!(psel && penable && !pwrite && !pready) |=> $stable(prdata))
		else $error("prdata moved");
	chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=>
		cmd_valid && $stable({cmd_addr, cmd_bytes, cmd_host_privilege_level, cmd_hostid})) else $error("cmd dropped");
	chk_cmd_size: assert property (cmd_valid |-> cmd_bytes != 16'h0000 && cmd_bytes <= 16'h0040)
		else $error("cmd size");
	chk_done_pulse: assert property (done |=> !done) else $error("done too long");
	chk_take_busy: assert property (sub_valid && sub_ready |=> !sub_ready) else $error("still ready");
	cov_take: cover property (sub_valid && sub_ready);
	cov_stall: cover property (cmd_valid && !cmd_ready);
	cov_err: cover property (pslverr);
	cov_done: cover property (done);
endmodule // drsas_props
bind drsas_top drsas_props drsas_props_i (.*);

// *** test/tb_drsas_top.sv ***
// self-checking bench for the read-side active state block
// assumes the package, interface, design and endpoint model compile first
`timescale 1ns/1ps
module tb_drsas_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sub_valid = 1'b0;
	logic sub_ready;
	logic [31:0] sub_src_addr = 32'h0;
	logic [15:0] sub_byte_count = 16'h0;
	logic [15:0] sub_array_count = 16'h0;
	logic [15:0] sub_src_stride = 16'h0;
	logic sub_host_privilege_level = 1'b0;
	logic [3:0] sub_hostid = 4'h0;
	logic sub_addr_mode = 1'b0;
	logic [2:0] sub_wrap_sel = 3'h0;
	logic cmd_valid;
	logic cmd_ready;
	logic [31:0] cmd_addr;
	logic [15:0] cmd_bytes;
	logic cmd_host_privilege_level;
	logic [3:0] cmd_hostid;
	logic done;
	logic slow = 1'b0;
	logic [4:0] ea = 5'h0;
	logic [31:0] fin = 32'h0;
	logic [47:0] q[$];
	logic [47:0] eq[$];
	int checks = 0;
	int mismatches = 0;
	int dn = 0;
	drsas_top drsas_top_i (.*);
	drsas_ep drsas_ep_i (.*);
	initial
	begin
		forever #20 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checks++;
		if (got !== ex)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog bounds this wait
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
		logic [31:0] r;
		logic e;
		apb(a, 1'b0, 32'h0, r, e);
		chk(nm, ex, r);
	endtask
	always @(posedge pclk)
	begin
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
		begin
			q.push_back({cmd_addr, cmd_bytes});
			chk("cmd_attr", ea, {cmd_host_privilege_level, cmd_hostid});
		end
		if (done === 1'b1)
			dn++;
	end
	task automatic run(input logic [31:0] a0, input logic [15:0] ac, input logic [15:0] bc, input logic [15:0] st,
		input logic sm, input logic [2:0] fw, input logic [4:0] at);
		logic [31:0] a;
		logic [31:0] s;
		logic [15:0] left;
		logic [15:0] sz;
		logic [15:0] mx;
		int n;
		int d0;
		q.delete();
		eq.delete();
		ea = at;
		d0 = dn;
		mx = sm ? (16'h0001 << ((fw > 3'h5) ? 3'h5 : fw)) : drsas_pkg::CMD_MAX_BYTES;
		s = a0;
		a = a0;
		for (int b = 0; b < bc; b++)
		begin
			left = ac;
			a = s;
			while (left != 16'h0)
			begin
				sz = (left < mx) ? left : mx;
				eq.push_back({a, sz});
				left = left - sz;
				a = sm ? s : a + sz;
			end
			s = s + st;
		end
		fin = a;
		n = 0;
		while (sub_ready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		sub_valid <= 1'b1;
		sub_src_addr <= a0;
		sub_byte_count <= ac;
		sub_array_count <= bc;
		sub_src_stride <= st;
		sub_addr_mode <= sm;
		sub_wrap_sel <= fw;
		{sub_host_privilege_level, sub_hostid} <= at;
		@(posedge pclk);
		sub_valid <= 1'b0;
		{sub_host_privilege_level, sub_hostid} <= ~at;
		n = 0;
		while ((q.size() < eq.size() || dn == d0) && n < 500)
		begin
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
		chk("done_pulses", 1, dn - d0);
		chk("cmd_count", eq.size(), q.size());
		for (int i = 0; i < eq.size() && i < q.size(); i++)
		begin
			chk("cmd_addr", eq[i][47:16], q[i][47:16]);
			chk("cmd_bytes", eq[i][15:0], q[i][15:0]);
		end
	endtask
	task automatic t_reset;
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 6; i++)
			rd("reset_value", 8'(4 * i), 32'h0);
		apb(8'h20, 1'b0, 32'h0, r, e);
		chk("unmapped_err", 1, e);
		apb(drsas_pkg::OFF_SRC, 1'b1, 32'hFFFF_FFFF, r, e);
		chk("ro_write_err", 0, e);
		rd("src_after_write", drsas_pkg::OFF_SRC, 32'h0);
		apb(drsas_pkg::OFF_CTRL, 1'b1, 32'h0000_0001, r, e);
		rd("pause_set", drsas_pkg::OFF_CTRL, 32'h0000_0001);
		rd("status_idle", drsas_pkg::OFF_STAT, 32'h0);
		apb(drsas_pkg::OFF_CTRL, 1'b1, 32'h0, r, e);
		rd("pause_clear", drsas_pkg::OFF_CTRL, 32'h0);
	endtask
	task automatic t_incrementing_addressing;
		slow <= 1'b1;
		run(32'h0000_1000, 16'h0064, 16'h0002, 16'h0200, 1'b0, 3'h0, 5'h1A);
		rd("counts", drsas_pkg::OFF_CNT, 32'h0);
		rd("src_addr", drsas_pkg::OFF_SRC, fin);
		rd("dst_addr", drsas_pkg::OFF_DST, 32'h0);
		rd("stride", drsas_pkg::OFF_IDX, 32'h0000_0200);
		rd("proxy", drsas_pkg::OFF_PRXY, 32'h0000_010A);
		rd("reload", drsas_pkg::OFF_RLD, 32'h0000_0064);
		slow <= 1'b0;
	endtask
	task automatic t_const;
		for (int f = 0; f < 8; f++)
			run(32'h0000_2000, 16'h0002 << ((f > 5) ? 5 : f), 16'h0001, 16'h0000, 1'b1, 3'(f), 5'(f));
		rd("proxy_user", drsas_pkg::OFF_PRXY, 32'h0000_0007);
		run(32'h0000_3000, 16'h0000, 16'h0003, 16'h0010, 1'b0, 3'h0, 5'h10);
		rd("counts_zero", drsas_pkg::OFF_CNT, 32'h0);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_incrementing_addressing();
		t_const();
		tally_and_finish();
	end
	// generous bound, the sequence needs a few hundred cycles
	initial
	begin
		#400000;
		mismatches++;
		tally_and_finish();
	end
endmodule // tb_drsas_top
